//--- pio_pins_model.sv
// board side of the pins: a driven pin shows the block level, else its outside source
`timescale 1ns/1ps
module pio_pins_model (
	// block drives
	input wire pio_pkg::pio_drive8_t	a_drv_i,
	input wire pio_pkg::pio_drive8_t	b_drv_i,
	input wire pio_pkg::pio_drive8_t	c_drv_i,
	input wire pio_pkg::pio_drive4_t	f_drv_i,
	// outside sources
	input wire logic [7:0]			a_ext_i,
	input wire logic [7:0]			b_ext_i,
	input wire logic [7:0]			c_ext_i,
	input wire logic [3:0]			f_ext_i,
	// wire levels
	output logic [7:0]			a_pin_o,
	output logic [7:0]			b_pin_o,
	output logic [7:0]			c_pin_o,
	output logic [3:0]			f_pin_o
);
	import pio_pkg::*;
	// each wire takes the level of whichever party enables it
	assign a_pin_o = (a_drv_i.enable & a_drv_i.level) | (~a_drv_i.enable & a_ext_i);
	assign b_pin_o = (b_drv_i.enable & b_drv_i.level) | (~b_drv_i.enable & b_ext_i);
	assign c_pin_o = (c_drv_i.enable & c_drv_i.level) | (~c_drv_i.enable & c_ext_i);
	assign f_pin_o = (f_drv_i.enable & f_drv_i.level) | (~f_drv_i.enable & f_ext_i);
endmodule

//--- pio_pkg.sv
// package with the register map, field positions and bus carriers of the parallel port block
package pio_pkg;

	// bus geometry
	localparam int PIO_DATA_W = 32;                 // apb data width
	localparam int PIO_ADDR_W = 8;                  // apb byte address width
	localparam int PIO_IDX_W  = 6;                  // register index width

	// register indices, byte address is four times the index
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_A_DATA = 6'h00;  // first port data
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_B_DATA = 6'h01;  // second port data
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_C_DATA = 6'h02;  // third port data
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_D_IN   = 6'h03;  // first input-only port
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_A_DIR  = 6'h04;  // first port direction
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_B_DIR  = 6'h05;  // second port direction
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_C_DIR  = 6'h06;  // third port direction
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_E_IN   = 6'h2B;  // second input-only port
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_F_DATA = 6'h2C;  // nibble port data
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_F_DIR  = 6'h2E;  // nibble port direction
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_CTRL   = 6'h30;  // control bits
	localparam logic [PIO_IDX_W-1:0] PIO_IDX_STAT   = 6'h31;  // interrupt latches

	// reset values
	localparam logic [7:0] PIO_DIR_RST  = 8'h00;    // all pins input
	localparam logic [3:0] PIO_DIRF_RST = 4'h0;     // nibble port all input
	localparam logic [2:0] PIO_CTRL_RST = 3'h0;     // all features off
	localparam logic [1:0] PIO_STAT_RST = 2'h0;     // no request pending

	// control register fields
	localparam int PIO_CTRL_OCE_BIT  = 0; // compare_output_enable
	localparam int PIO_CTRL_SPE_BIT  = 1; // serial_interface_enable
	localparam int PIO_CTRL_WAKE_BIT = 2; // wake on port interrupt

	// status register fields
	localparam int PIO_STAT_A_BIT = 0; // first port request latch
	localparam int PIO_STAT_C_BIT = 1; // third port request latch

	// shared pin positions
	localparam int PIO_PB_CAP_BIT = 7; // timer_capture_input pin
	localparam int PIO_PB_CMP_BIT = 6; // timer_compare_output pin
	localparam int PIO_PF_SS_BIT  = 0; // slave select pin
	localparam int PIO_ADC_E_BIT  = 3; // channel bit picking port e
	localparam int PIO_ADC_INT_BIT = 4; // channel bit for internal refs

	// pin drive of an 8-bit port
	typedef struct packed {
		logic [7:0] level; // value driven
		logic [7:0] enable; // high while driven
	} pio_drive8_t;

	// pin drive of the nibble port
	typedef struct packed {
		logic [3:0] level; // value driven
		logic [3:0] enable; // high while driven
	} pio_drive4_t;

	// apb request from the master
	typedef struct packed {
		logic                  psel; // slave selected
		logic                  penable; // access phase
		logic                  pwrite; // write direction
		logic [PIO_ADDR_W-1:0] paddr; // byte address
		logic [PIO_DATA_W-1:0] pwdata; // write data
	} pio_apb_req_t;

	// apb answer to the master
	typedef struct packed {
		logic [PIO_DATA_W-1:0] prdata; // read data
		logic                  pready; // transfer ends
		logic                  pslverr; // unmapped address
	} pio_apb_rsp_t;

endpackage

//--- pio_ports.sv
// parallel i/o port block: three byte ports, a nibble port, two input-only ports, apb registers
//
// Behaviour
// - 28 bidirectional lines, 16 input-only lines
// - direction bit 0 input, 1 output
// - output pins drive the data register bit
// - input pins read back the pin level
// - reset clears direction, keeps data
// - first/third port at 0,4 and 2,6
// - second port at 1 and 5
// - port a/c inputs ANDed into interrupt
// - separate request latch per interrupt port
// - latches set on falling edge only
// - output pins excluded from interrupt AND
// - a low input masks other falling pins
// - branch tests see dedicated irq pin only
// - compare enable gives timer pins on b7/b6
// - input-only ports at 03 and 2B
// - selected channel reads zero while converting
// - nibble port at 2C and 2E
// - serial enable takes nibble bits 3..1
// - nibble bit 0 slave select or output
// - hardware sets serial-owned direction bits
// - nibble data readable under serial use
// - port falling edge wakes when enabled
`timescale 1ns/1ps
module pio_ports (
	// clock and reset
	input  wire logic                  mclk_i,
	input  wire logic                  sys_rst_i,
	// apb slave
	input  wire pio_pkg::pio_apb_req_t apb_i,
	output pio_pkg::pio_apb_rsp_t      apb_o,
	// byte ports
	input  wire logic [7:0]            port_a_pin_i,
	output pio_pkg::pio_drive8_t       port_a_drive_o,
	input  wire logic [7:0]            port_b_pin_i,
	output pio_pkg::pio_drive8_t       port_b_drive_o,
	input  wire logic [7:0]            port_c_pin_i,
	output pio_pkg::pio_drive8_t       port_c_drive_o,
	// input-only ports
	input  wire logic [7:0]            port_d_pin_i,
	input  wire logic [7:0]            port_e_pin_i,
	// nibble port
	input  wire logic [3:0]            port_f_pin_i,
	output pio_pkg::pio_drive4_t       port_f_drive_o,
	// dedicated interrupt pin
	input  wire logic                  irq_pin_n_i,
	// timer hookup
	input  wire logic                  timer_compare_output_i,
	output logic                       timer_capture_input_o,
	// serial interface hookup
	input  wire logic [3:1]            spi_out_i,
	input  wire logic [3:1]            spi_dir_i,
	output logic      [3:1]            spi_pin_o,
	output logic                       spi_slave_select_n_o,
	// a/d converter state
	input  wire logic                  adc_active_i,
	input  wire logic [4:0]            adc_channel_i,
	// cpu side
	output logic                       port_irq_o,
	output logic                       irq_pin_level_o,
	output logic                       wake_o,
	output logic                       compare_output_enable_o,
	output logic                       serial_interface_enable_o
);

	import pio_pkg::*;

	localparam int SYNC_W = 45; // 5 bytes, a nibble, the irq pin

	// register storage
	logic [7:0] data_a_reg; // first port data, not reset
	logic [7:0] data_b_reg; // second port data, not reset
	logic [7:0] data_c_reg; // third port data, not reset
	logic [3:0] data_f_reg; // nibble port data, not reset
	logic [7:0] dir_a_reg; // first_port_direction
	logic [7:0] dir_b_reg; // second_port_direction
	logic [7:0] dir_c_reg; // third_port_direction
	logic [3:0] dir_f_reg; // nibble_port_direction
	logic [2:0] ctrl_reg; // feature enables
	logic [1:0] stat_reg; // port request latches

	// synchronised pins
	logic [SYNC_W-1:0] sync_in; // raw pins to synchroniser
	logic [SYNC_W-1:0] sync_out; // settled pins
	logic [7:0]        pin_a; // settled first port
	logic [7:0]        pin_b; // settled second port
	logic [7:0]        pin_c; // settled third port
	logic [7:0]        pin_d; // settled input port d
	logic [7:0]        pin_e; // settled input port e
	logic [3:0]        pin_f; // settled nibble port
	logic              pin_irq_n; // settled dedicated irq pin

	// interrupt detection
	logic comb_a; // AND of participating a inputs
	logic comb_c; // AND of participating c inputs
	logic comb_a_reg; // last combined a level
	logic comb_c_reg; // last combined c level
	logic fall_a; // combined a fell
	logic fall_c; // combined c fell

	// bus handling
	logic                  pready_reg; // answer flag
	logic [PIO_DATA_W-1:0] prdata_reg; // captured read data
	logic                  pslverr_reg; // error flag
	logic                  acc_phase; // access cycle before answer
	logic                  wr_en; // write commits this edge
	logic [PIO_IDX_W-1:0]  idx; // addressed register
	logic                  aligned; // low address bits zero
	logic [7:0]            rd_val; // read mux result
	logic                  rd_hit; // address is mapped
	logic                  serial_interface_enable; // serial interface on
	logic                  compare_output_enable; // timer pins on

	// output flip-flops
	pio_drive8_t drive_a_reg; // first port drive
	pio_drive8_t drive_b_reg; // second port drive
	pio_drive8_t drive_c_reg; // third port drive
	pio_drive4_t drive_f_reg; // nibble port drive
	logic        port_irq_reg; // combined request
	logic        irq_level_reg; // dedicated pin level
	logic        wake_reg; // wake request
	logic        capture_reg; // timer capture level
	logic [3:1]  spi_pin_reg; // serial pin levels
	logic        ss_n_reg; // slave select

	// read value of a bidirectional bit set: data where output, pin where input
	function automatic logic [7:0] pio_bidir_read(input logic [7:0] data, input logic [7:0] dir,
		input logic [7:0] pin);
		pio_bidir_read = (dir & data) | (~dir & pin);
	endfunction

	// input-only port read with the converting channel forced to zero
	function automatic logic [7:0] pio_adc_mask(input logic [7:0] pin, input logic port_e);
		logic [7:0] mask;
		mask = 8'h00;
		if (adc_active_i && !adc_channel_i[PIO_ADC_INT_BIT] && (adc_channel_i[PIO_ADC_E_BIT] == port_e)) begin
			mask[adc_channel_i[2:0]] = 1'b1;
		end
		pio_adc_mask = pin & ~mask;
	endfunction

	// all external lines pass the three-stage synchroniser
	assign sync_in = {irq_pin_n_i, port_f_pin_i, port_e_pin_i, port_d_pin_i,
		port_c_pin_i, port_b_pin_i, port_a_pin_i};

	pio_sync #(
		.W (SYNC_W)
	) u_sync (
		.mclk_i    (mclk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   (sync_in),
		.sync_o    (sync_out)
	);

	assign pin_a     = sync_out[7:0];
	assign pin_b     = sync_out[15:8];
	assign pin_c     = sync_out[23:16];
	assign pin_d     = sync_out[31:24];
	assign pin_e     = sync_out[39:32];
	assign pin_f     = sync_out[43:40];
	assign pin_irq_n = sync_out[44];

	assign serial_interface_enable = ctrl_reg[PIO_CTRL_SPE_BIT];
	assign compare_output_enable = ctrl_reg[PIO_CTRL_OCE_BIT];

	// bus decode: one wait state, the write lands on the completing edge
	assign idx       = apb_i.paddr[PIO_ADDR_W-1:2];
	assign aligned   = (apb_i.paddr[1:0] == 2'h0);
	assign acc_phase = apb_i.psel && apb_i.penable && !pready_reg;
	assign wr_en     = apb_i.psel && apb_i.penable && pready_reg && apb_i.pwrite && aligned;

	// read multiplexer over the register map
	always_comb begin
		rd_val = 8'h00;
		rd_hit = aligned;
		case (idx)
			PIO_IDX_A_DATA: rd_val = pio_bidir_read(data_a_reg, dir_a_reg, pin_a);
			PIO_IDX_B_DATA: rd_val = pio_bidir_read(data_b_reg, dir_b_reg, pin_b);
			PIO_IDX_C_DATA: rd_val = pio_bidir_read(data_c_reg, dir_c_reg, pin_c);
			PIO_IDX_D_IN:   rd_val = pio_adc_mask(pin_d, 1'b0);
			PIO_IDX_A_DIR:  rd_val = dir_a_reg;
			PIO_IDX_B_DIR:  rd_val = dir_b_reg;
			PIO_IDX_C_DIR:  rd_val = dir_c_reg;
			PIO_IDX_E_IN:   rd_val = pio_adc_mask(pin_e, 1'b1);
			PIO_IDX_F_DATA: begin
				// stays readable while the serial interface owns bits 3..1
				rd_val = pio_bidir_read({4'h0, data_f_reg}, {4'h0, dir_f_reg},
					{4'h0, pin_f});
			end
			PIO_IDX_F_DIR:  rd_val = {4'h0, dir_f_reg};
			PIO_IDX_CTRL:   rd_val = {5'h00, ctrl_reg};
			PIO_IDX_STAT:   rd_val = {6'h00, stat_reg};
			default:        rd_hit = 1'b0;           // unmapped reads zero with error
		endcase
	end

	// apb answer: pready rises one cycle into the access phase
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end else if (acc_phase) begin
			pready_reg  <= 1'b1;
			prdata_reg  <= apb_i.pwrite ? '0 : {24'h000000, rd_val};
			pslverr_reg <= !rd_hit;
		end else begin
			pready_reg  <= 1'b0;
			prdata_reg  <= '0;
			pslverr_reg <= 1'b0;
		end
	end

	assign apb_o.pready  = pready_reg;
	assign apb_o.prdata  = prdata_reg;
	assign apb_o.pslverr = pslverr_reg;

	// data registers keep their contents through reset
	always_ff @(posedge mclk_i) begin
		if (wr_en) begin
			case (idx)
				PIO_IDX_A_DATA: data_a_reg <= apb_i.pwdata[7:0];
				PIO_IDX_B_DATA: data_b_reg <= apb_i.pwdata[7:0];
				PIO_IDX_C_DATA: data_c_reg <= apb_i.pwdata[7:0];
				PIO_IDX_F_DATA: data_f_reg <= apb_i.pwdata[3:0];
				default: ;                           // other registers elsewhere
			endcase
		end
	end

	// byte port direction registers, cleared by reset
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			dir_a_reg <= PIO_DIR_RST;
			dir_b_reg <= PIO_DIR_RST;
			dir_c_reg <= PIO_DIR_RST;
		end else if (wr_en) begin
			if (idx == PIO_IDX_A_DIR) begin
				dir_a_reg <= apb_i.pwdata[7:0];
			end
			if (idx == PIO_IDX_B_DIR) begin
				dir_b_reg <= apb_i.pwdata[7:0];
			end
			if (idx == PIO_IDX_C_DIR) begin
				dir_c_reg <= apb_i.pwdata[7:0];
			end
		end
	end

	// nibble direction: hardware owns bits 3..1 while serial is on
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			dir_f_reg <= PIO_DIRF_RST;
		end else begin
			if (wr_en && idx == PIO_IDX_F_DIR) begin
				dir_f_reg[0] <= apb_i.pwdata[0];
				if (!serial_interface_enable) begin
					dir_f_reg[3:1] <= apb_i.pwdata[3:1];
				end
			end
			if (serial_interface_enable) begin
				dir_f_reg[3:1] <= spi_dir_i;
			end
		end
	end

	// control register
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			ctrl_reg <= PIO_CTRL_RST;
		end else if (wr_en && idx == PIO_IDX_CTRL) begin
			ctrl_reg <= apb_i.pwdata[2:0];
		end
	end

	// combined port levels: output pins count as high so they never pull it low
	assign comb_a = &(pin_a | dir_a_reg);
	assign comb_c = &(pin_c | dir_c_reg);
	assign fall_a = comb_a_reg && !comb_a;
	assign fall_c = comb_c_reg && !comb_c;

	// previous combined levels, idle high so reset makes no edge when the combined line is high at release
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			comb_a_reg <= 1'b1;
			comb_c_reg <= 1'b1;
		end else begin
			comb_a_reg <= comb_a;
			comb_c_reg <= comb_c;
		end
	end

	// request latches, write one to acknowledge, a new edge beats the clear
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			stat_reg <= PIO_STAT_RST;
		end else begin
			if (fall_a) begin
				stat_reg[PIO_STAT_A_BIT] <= 1'b1;
			end else if (wr_en && idx == PIO_IDX_STAT && apb_i.pwdata[PIO_STAT_A_BIT]) begin
				stat_reg[PIO_STAT_A_BIT] <= 1'b0;
			end
			if (fall_c) begin
				stat_reg[PIO_STAT_C_BIT] <= 1'b1;
			end else if (wr_en && idx == PIO_IDX_STAT && apb_i.pwdata[PIO_STAT_C_BIT]) begin
				stat_reg[PIO_STAT_C_BIT] <= 1'b0;
			end
		end
	end

	// cpu-facing interrupt, wake and pin-level outputs
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			port_irq_reg  <= 1'b0;
			irq_level_reg <= 1'b1;
			wake_reg      <= 1'b0;
		end else begin
			port_irq_reg  <= |stat_reg;
			irq_level_reg <= pin_irq_n;
			wake_reg      <= ctrl_reg[PIO_CTRL_WAKE_BIT] && (fall_a || fall_c);
		end
	end

	// byte port pin drive, timer takes b7/b6 under compare enable
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			drive_a_reg <= '0;
			drive_b_reg <= '0;
			drive_c_reg <= '0;
			capture_reg <= 1'b0;
		end else begin
			drive_a_reg.level  <= data_a_reg;
			drive_a_reg.enable <= dir_a_reg;
			drive_c_reg.level  <= data_c_reg;
			drive_c_reg.enable <= dir_c_reg;
			drive_b_reg.level  <= data_b_reg;
			drive_b_reg.enable <= dir_b_reg;
			if (compare_output_enable) begin
				drive_b_reg.level[PIO_PB_CMP_BIT]  <= timer_compare_output_i;
				drive_b_reg.enable[PIO_PB_CMP_BIT] <= 1'b1;
				drive_b_reg.enable[PIO_PB_CAP_BIT] <= 1'b0;
			end
			capture_reg <= compare_output_enable && pin_b[PIO_PB_CAP_BIT];
		end
	end

	// nibble port drive and serial pin hookup
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			drive_f_reg <= '0;
			spi_pin_reg <= 3'h0;
			ss_n_reg    <= 1'b1;
		end else begin
			drive_f_reg.level[0]  <= data_f_reg[0];
			drive_f_reg.enable[0] <= dir_f_reg[0];
			if (serial_interface_enable) begin
				drive_f_reg.level[3:1]  <= spi_out_i;
				drive_f_reg.enable[3:1] <= dir_f_reg[3:1];
			end else begin
				drive_f_reg.level[3:1]  <= data_f_reg[3:1];
				drive_f_reg.enable[3:1] <= dir_f_reg[3:1];
			end
			spi_pin_reg <= pin_f[3:1];
			ss_n_reg    <= !(serial_interface_enable && !dir_f_reg[PIO_PF_SS_BIT]) || pin_f[PIO_PF_SS_BIT];
		end
	end

	// outputs straight from flip-flops
	assign port_a_drive_o            = drive_a_reg;
	assign port_b_drive_o            = drive_b_reg;
	assign port_c_drive_o            = drive_c_reg;
	assign port_f_drive_o            = drive_f_reg;
	assign timer_capture_input_o     = capture_reg;
	assign spi_pin_o                 = spi_pin_reg;
	assign spi_slave_select_n_o      = ss_n_reg;
	assign port_irq_o                = port_irq_reg;
	assign irq_pin_level_o           = irq_level_reg;
	assign wake_o                    = wake_reg;
	assign compare_output_enable_o   = ctrl_reg[PIO_CTRL_OCE_BIT];
	assign serial_interface_enable_o = ctrl_reg[PIO_CTRL_SPE_BIT];

endmodule

//--- pio_ports_checker.sv
// concurrent checks on the parallel port block ports
`timescale 1ns/1ps
module pio_ports_checker (
	// clock, reset and bus
	input wire logic			mclk_i,
	input wire logic			sys_rst_i,
	input wire pio_pkg::pio_apb_req_t	apb_i,
	input wire pio_pkg::pio_apb_rsp_t	apb_o,
	// pins and drives
	input wire logic [7:0]			port_a_pin_i,
	input wire logic [7:0]			port_c_pin_i,
	input wire pio_pkg::pio_drive8_t	port_a_drive_o,
	input wire pio_pkg::pio_drive8_t	port_b_drive_o,
	input wire pio_pkg::pio_drive8_t	port_c_drive_o,
	input wire pio_pkg::pio_drive4_t	port_f_drive_o,
	// shared functions
	input wire logic			irq_pin_n_i,
	input wire logic			timer_compare_output_i,
	input wire logic			timer_capture_input_o,
	input wire logic [3:1]			spi_out_i,
	input wire logic [3:1]			spi_dir_i,
	input wire logic			spi_slave_select_n_o,
	input wire logic			adc_active_i,
	input wire logic [4:0]			adc_channel_i,
	// cpu side
	input wire logic			port_irq_o,
	input wire logic			irq_pin_level_o,
	input wire logic			compare_output_enable_o,
	input wire logic			serial_interface_enable_o
);
	import pio_pkg::*;
	logic [3:0] lo_age;	// cycles since a combined line was last low
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	// age of the last low on either combined interrupt line, saturating
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i || !(&(port_a_pin_i | port_a_drive_o.enable)) || !(&(port_c_pin_i | port_c_drive_o.enable))) begin
			lo_age <= 4'h0;
		end else if (lo_age != 4'hF) begin
			lo_age <= lo_age + 4'h1;
		end
	end
	sequence s_acc;	// access edge, answer still pending
		apb_i.psel && apb_i.penable && !apb_o.pready;
	endsequence
	sequence s_wr_done;	// write completes at this edge
		apb_i.psel && apb_i.penable && apb_o.pready && apb_i.pwrite;
	endsequence
	property p_dir;
		logic [7:0] v;
		(s_wr_done ##0 apb_i.paddr == 8'h10, v = apb_i.pwdata[7:0]) |-> ##2 port_a_drive_o.enable == v;
	endproperty
	property p_rst;
		$fell(sys_rst_i) |-> !(|{port_a_drive_o.enable, port_b_drive_o.enable, port_c_drive_o.enable,
			port_f_drive_o.enable, port_irq_o});
	endproperty
	property p_irq;
		$rose(port_irq_o) |-> lo_age <= 4'hA;
	endproperty
	property p_pin;
		$stable(irq_pin_n_i) [*6] |-> irq_pin_level_o == irq_pin_n_i;
	endproperty
	property p_cmp;
		(compare_output_enable_o && $stable(timer_compare_output_i)) [*3] |-> port_b_drive_o.enable[6]
			&& !port_b_drive_o.enable[7] && port_b_drive_o.level[6] == timer_compare_output_i;
	endproperty
	property p_cap;
		(!compare_output_enable_o) [*3] |-> !timer_capture_input_o;
	endproperty
	property p_adc;
		logic [2:0] ch;
		(s_acc ##0 !apb_i.pwrite && apb_i.paddr == 8'h0C && adc_active_i && adc_channel_i < 5'h08,
			ch = adc_channel_i[2:0]) |=> apb_o.pready && !apb_o.prdata[ch];
	endproperty
	property p_spi;
		(serial_interface_enable_o && $stable(spi_dir_i) && $stable(spi_out_i)) [*4] |->
			port_f_drive_o.enable[3:1] == spi_dir_i && port_f_drive_o.level[3:1] == spi_out_i;
	endproperty
	property p_ss;
		(!serial_interface_enable_o) [*3] |-> spi_slave_select_n_o;
	endproperty
	a_dir: assert property (p_dir) else $error("dir write not on drive");
	a_rst: assert property (p_rst) else $error("drive after reset");
	a_irq: assert property (p_irq) else $error("irq without fall");
	a_pin: assert property (p_pin) else $error("irq pin level");
	a_cmp: assert property (p_cmp) else $error("compare pin");
	a_cap: assert property (p_cap) else $error("capture idle");
	a_adc: assert property (p_adc) else $error("adc bit not zero");
	a_spi: assert property (p_spi) else $error("serial dirs");
	a_ss: assert property (p_ss) else $error("slave select idle");
endmodule
bind pio_ports pio_ports_checker u_chk (.*);

//--- pio_sync.sv
// three-stage pin synchroniser that passes a change once stages two and three agree
`timescale 1ns/1ps
module pio_sync #(
	parameter int W = 8                             // number of lines
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         sys_rst_i,
	// lines in and settled out
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] st1_reg;                          // first stage, read only by st2
	logic [W-1:0] st2_reg;                          // second stage
	logic [W-1:0] st3_reg;                          // third stage
	logic [W-1:0] out_reg;                          // settled value

	// shift chain, no reset needed on the metastable stages
	always_ff @(posedge mclk_i) begin
		st1_reg <= async_i;
		st2_reg <= st1_reg;
		st3_reg <= st2_reg;
	end

	// accept a bit only when the last two stages agree; reset loads the pin level
	// so no false edge reaches the interrupt detectors at release
	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			out_reg <= st3_reg;
		end else begin
			out_reg <= (st2_reg & st3_reg) | (out_reg & (st2_reg | st3_reg));
		end
	end

	assign sync_o = out_reg;

endmodule

//--- tb_pio_ports.sv
// self-checking bench of the parallel port block
`timescale 1ns/1ps
module tb_pio_ports;
	import pio_pkg::*;
	logic		mclk_i = 1'b0;
	logic		sys_rst_i = 1'b1;
	pio_apb_req_t	req = '0;
	pio_apb_rsp_t	rsp;
	pio_drive8_t	drv [3];
	pio_drive4_t	drv_f;
	logic [7:0]	ext [3] = '{8'hFF, 8'hFF, 8'hFF};	// outside sources of ports a, b, c
	logic [7:0]	pin [3];
	logic [7:0]	ext_d = 8'hFF;
	logic [7:0]	ext_e = 8'hFF;
	logic [3:0]	ext_f = 4'hF;
	logic [3:0]	pin_f;
	logic		irq_n = 1'b1;
	logic		timer_compare_output = 1'b0;
	logic [3:1]	sp_out = 3'h0;
	logic [3:1]	sp_dir = 3'h0;
	logic [3:1]	spo;
	logic		adc_on = 1'b0;
	logic [4:0]	adc_ch = 5'h00;
	logic		timer_capture_input, ss_n, pirq, plev, wake, compare_output_enable, serial_interface_enable, err;
	logic [31:0]	rd;
	logic		wake_seen = 1'b0;
	int		bad_count = 0;
	int		tests_run = 0;
	int		cyc = 0;
	always #2.5 mclk_i = ~mclk_i;
	pio_ports DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .apb_i(req), .apb_o(rsp), .port_a_pin_i(pin[0]),
		.port_a_drive_o(drv[0]), .port_b_pin_i(pin[1]), .port_b_drive_o(drv[1]), .port_c_pin_i(pin[2]),
		.port_c_drive_o(drv[2]), .port_d_pin_i(ext_d), .port_e_pin_i(ext_e), .port_f_pin_i(pin_f),
		.port_f_drive_o(drv_f), .irq_pin_n_i(irq_n), .timer_compare_output_i(timer_compare_output), .timer_capture_input_o(timer_capture_input),
		.spi_out_i(sp_out), .spi_dir_i(sp_dir), .spi_pin_o(spo), .spi_slave_select_n_o(ss_n), .adc_active_i(adc_on),
		.adc_channel_i(adc_ch), .port_irq_o(pirq), .irq_pin_level_o(plev), .wake_o(wake),
		.compare_output_enable_o(compare_output_enable), .serial_interface_enable_o(serial_interface_enable));
	pio_pins_model u_pins (.a_drv_i(drv[0]), .b_drv_i(drv[1]), .c_drv_i(drv[2]), .f_drv_i(drv_f),
		.a_ext_i(ext[0]), .b_ext_i(ext[1]), .c_ext_i(ext[2]), .f_ext_i(ext_f),
		.a_pin_o(pin[0]), .b_pin_o(pin[1]), .c_pin_o(pin[2]), .f_pin_o(pin_f));
	// cycle ceiling and wake pulse catcher
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (wake === 1'b1) begin
			wake_seen <= 1'b1;
		end
		if (cyc == 5000) begin
			bad_count++;
			test_done();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
		req <= '{1'b1, 1'b0, wr, ad, wd};
		@(posedge mclk_i);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk_i);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
		@(posedge mclk_i);
	endtask
	task automatic rdc(input string nm, input logic [7:0] ad, input logic [7:0] exp);
		apb(1'b0, ad, 32'h0);
		chk(nm, {24'h0, exp}, rd);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic t_map();
		rdc("a dir", 8'h10, 8'h00);
		rdc("b dir", 8'h14, 8'h00);
		rdc("f dir", 8'hB8, 8'h00);
		apb(1'b1, 8'h00, 32'h5A);
		apb(1'b1, 8'h08, 32'hC3);
		apb(1'b1, 8'h18, 32'hFF);
		sys_rst_i <= 1'b1;
		wt(12);
		sys_rst_i <= 1'b0;
		rdc("c dir", 8'h18, 8'h00);
		apb(1'b1, 8'h10, 32'hFF);
		apb(1'b1, 8'h18, 32'hFF);
		rdc("a kept", 8'h00, 8'h5A);
		rdc("c kept", 8'h08, 8'hC3);
		$display("map test ended");
	endtask
	task automatic t_ports();
		for (int i = 0; i < 3; i++) begin
			ext[i] <= 8'h3C;
			apb(1'b1, 8'(i * 4), 32'hA5);
			apb(1'b1, 8'(16 + i * 4), 32'h0F);
			wt(8);
			rdc("port read", 8'(i * 4), 8'h35);
			chk("pin level", 32'h35, {24'h0, pin[i]});
		end
		$display("port test ended");
	endtask
	task automatic t_irq();
		ext[0] <= 8'hFF;
		ext[2] <= 8'hFF;
		apb(1'b1, 8'h00, 32'h00);
		apb(1'b1, 8'h10, 32'h01);
		apb(1'b1, 8'h18, 32'h00);
		wt(8);
		apb(1'b1, 8'hC4, 32'h03);
		rdc("no request", 8'hC4, 8'h00);
		ext[0] <= 8'hFD;
		wt(8);
		rdc("a request", 8'hC4, 8'h01);
		chk("port irq", 32'h1, {31'h0, pirq});
		chk("branch level", 32'h1, {31'h0, plev});
		apb(1'b1, 8'hC4, 32'h01);
		rdc("a cleared", 8'hC4, 8'h00);
		ext[0] <= 8'hF9;
		wt(8);
		rdc("masked fall", 8'hC4, 8'h00);
		ext[0] <= 8'hFF;
		apb(1'b1, 8'hC0, 32'h04);
		ext[2] <= 8'hDF;
		wt(8);
		rdc("c request", 8'hC4, 8'h02);
		chk("wake", 32'h1, {31'h0, wake_seen});
		irq_n <= 1'b0;
		wt(8);
		chk("branch pin", 32'h0, {31'h0, plev});
		apb(1'b1, 8'hC4, 32'h03);
		apb(1'b1, 8'hC0, 32'h00);
		$display("interrupt test ended");
	endtask
	task automatic t_adc();
		ext_e <= 8'h96;
		adc_on <= 1'b1;
		adc_ch <= 5'h03;
		wt(8);
		rdc("d selected", 8'h0C, 8'hF7);
		rdc("e other", 8'hAC, 8'h96);
		adc_ch <= 5'h09;
		rdc("e selected", 8'hAC, 8'h94);
		adc_ch <= 5'h10;
		rdc("d internal", 8'h0C, 8'hFF);
		adc_on <= 1'b0;
		rdc("d idle", 8'h0C, 8'hFF);
		$display("input port test ended");
	endtask
	task automatic t_shared();
		timer_compare_output <= 1'b1;
		ext[1] <= 8'h80;
		apb(1'b1, 8'hC0, 32'h01);
		wt(8);
		chk("compare pin", 32'h3, {30'h0, drv[1].enable[6], drv[1].level[6]});
		chk("capture", 32'h1, {31'h0, timer_capture_input});
		chk("enables", 32'h1, {30'h0, serial_interface_enable, compare_output_enable});
		sp_dir <= 3'b101;
		sp_out <= 3'b100;
		ext_f <= 4'hE;
		apb(1'b1, 8'hB0, 32'h05);
		apb(1'b1, 8'hC0, 32'h02);
		apb(1'b1, 8'hB8, 32'h00);
		wt(8);
		chk("serial dirs", 32'h5, {29'h0, drv_f.enable[3:1]});
		chk("serial pins", 32'h6, {29'h0, spo});
		chk("slave select", 32'h0, {31'h0, ss_n});
		chk("enables", 32'h2, {30'h0, serial_interface_enable, compare_output_enable});
		rdc("nibble data", 8'hB0, 8'h04);
		apb(1'b1, 8'hB8, 32'h01);
		wt(8);
		chk("f0 output", 32'h3, {30'h0, drv_f.enable[0], ss_n});
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped data", 32'h0, rd);
		chk("unmapped err", 32'h1, {31'h0, err});
		apb(1'b1, 8'hC0, 32'h00);
		$display("shared pin test ended");
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		wt(12);
		sys_rst_i <= 1'b0;
		t_map();
		t_ports();
		t_irq();
		t_adc();
		t_shared();
		test_done();
	end
endmodule
